// ---- hdl/flag_skip_unit.sv ----
// timer flag skip, system reset and detector arm execution unit
`timescale 1ns/1ps

// How it works
// - timer 3 skip tests its request flag
// - gate 0: skip when flag is 1
// - gate 0: the skip clears timer 3 flag
// - gate 1: timer 3 skip is a nop
// - timer 3 gate is bit 0, second control
// - timer 2 skip tests, skips, clears flag only with its gate low (bit 3, first control)
// - arm instruction keeps detector armed until reset
module flag_skip_unit
  import flag_skip_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // core side
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_code,
  input  wire logic               timer2_event,
  input  wire logic               timer3_event,
  output logic                    skip_next,
  output logic                    sys_reset_req,
  output logic                    vdet_armed,
  output logic                    timer2_request_flag,
  output logic                    timer3_request_flag,
  // axi4-lite slave
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when a byte address hits a mapped word
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == FIRST_CTRL_OFS) || (a == SECOND_CTRL_OFS) ||
                  (a == STATUS_OFS);
  endfunction : addr_mapped

  // low address bits of a bus address, upper bits must be zero
  function automatic logic addr_in_range(input logic [31:0] a);
    addr_in_range = (a[31:ADDR_W] == '0);
  endfunction : addr_in_range

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  decode_t           dec;                 // decoded instruction
  flags_t            flags_reg;           // flag state
  flags_t            flags_next;
  logic              sysrst_reg;          // reset request pulse
  logic              sysrst_next;
  logic [CTRL_W-1:0] first_ctrl_reg;      // first control register
  logic [CTRL_W-1:0] first_ctrl_next;
  logic [CTRL_W-1:0] second_ctrl_reg;     // second control register
  logic [CTRL_W-1:0] second_ctrl_next;
  logic              t2_gate;             // timer 2 gating bit
  logic              t3_gate;             // timer 3 gating bit
  // write channel state
  logic              aw_held_reg;         // write address captured
  logic              aw_held_next;
  logic [31:0]       aw_addr_reg;         // captured write address
  logic [31:0]       aw_addr_next;
  logic              w_held_reg;          // write data captured
  logic              w_held_next;
  logic [31:0]       w_data_reg;          // captured write data
  logic [31:0]       w_data_next;
  logic [3:0]        w_strb_reg;          // captured strobes
  logic [3:0]        w_strb_next;
  logic              awready_reg;
  logic              awready_next;
  logic              wready_reg;
  logic              wready_next;
  logic              bvalid_reg;
  logic              bvalid_next;
  logic [1:0]        bresp_reg;
  logic [1:0]        bresp_next;
  // read channel state
  logic              arready_reg;
  logic              arready_next;
  logic              rvalid_reg;
  logic              rvalid_next;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic [1:0]        rresp_reg;
  logic [1:0]        rresp_next;
  // register write strobes
  logic              wr_commit;           // both halves present
  logic              wr_first;            // write to first control
  logic              wr_second;           // write to second control

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  instr_decode instr_decode_inst (
    .code  (instr_code),
    .valid (instr_valid),
    .dec   (dec)
  );

  // gating bits from the control registers
  assign t2_gate = first_ctrl_reg[T2_GATE_POS];
  assign t3_gate = second_ctrl_reg[T3_GATE_POS];

  // ----------------------------------------------------------------
  // instruction execution
  // ----------------------------------------------------------------
  // flags: timer events set, skip instructions test and clear;
  // an event in the clearing cycle survives the clear
  always_comb begin
    flags_next      = flags_reg;
    flags_next.skip = 1'b0;
    sysrst_next     = 1'b0;
    // timer 3 skip, active only with its gate low
    if (dec.skip_t3 && !t3_gate) begin
      flags_next.skip    = flags_reg.t3_flag;
      flags_next.t3_flag = 1'b0;
    end
    // timer 2 skip, active only with its gate low
    if (dec.skip_t2 && !t2_gate) begin
      flags_next.skip    = flags_reg.t2_flag;
      flags_next.t2_flag = 1'b0;
    end
    // detector arm holds until reset
    if (dec.vdet_arm) begin
      flags_next.vdet_armed = 1'b1;
    end
    // timer events win over a same-cycle clear
    if (timer2_event) begin
      flags_next.t2_flag = 1'b1;
    end
    if (timer3_event) begin
      flags_next.t3_flag = 1'b1;
    end
    // system reset overrides everything else
    if (dec.sys_reset) begin
      flags_next  = FLAGS_RST;
      sysrst_next = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg  <= FLAGS_RST;
      sysrst_reg <= 1'b0;
    end else begin
      flags_reg  <= flags_next;
      sysrst_reg <= sysrst_next;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  assign wr_commit = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_first  = wr_commit && w_strb_reg[0] &&
                     addr_in_range(aw_addr_reg) &&
                     (aw_addr_reg[ADDR_W-1:0] == FIRST_CTRL_OFS);
  assign wr_second = wr_commit && w_strb_reg[0] &&
                     addr_in_range(aw_addr_reg) &&
                     (aw_addr_reg[ADDR_W-1:0] == SECOND_CTRL_OFS);

  // bus writes load, the reset instruction clears
  always_comb begin
    first_ctrl_next  = first_ctrl_reg;
    second_ctrl_next = second_ctrl_reg;
    if (wr_first) begin
      first_ctrl_next = w_data_reg[CTRL_W-1:0];
    end
    if (wr_second) begin
      second_ctrl_next = w_data_reg[CTRL_W-1:0];
    end
    if (dec.sys_reset) begin
      first_ctrl_next  = CTRL_RST;
      second_ctrl_next = CTRL_RST;
    end
  end

  // control register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_ctrl_reg  <= CTRL_RST;
      second_ctrl_reg <= CTRL_RST;
    end else begin
      first_ctrl_reg  <= first_ctrl_next;
      second_ctrl_reg <= second_ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  // address and data captured in either order, answer after both
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    // capture address
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    // capture data
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    // commit and raise the response
    if (wr_commit) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      if (addr_in_range(aw_addr_reg) &&
          addr_mapped(aw_addr_reg[ADDR_W-1:0])) begin
        bresp_next = RESP_OKAY;
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    // response taken
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // ready only while the half is still open
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
  end

  // write channel flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= DATA_ZERO;
      w_held_reg  <= 1'b0;
      w_data_reg  <= DATA_ZERO;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // ----------------------------------------------------------------
  // read channels
  // ----------------------------------------------------------------
  // one read at a time, data one cycle after the address
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    // address taken, build the answer
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next  = 1'b1;
      arready_next = 1'b0;
      rdata_next   = DATA_ZERO;
      rresp_next   = RESP_OKAY;
      if (!addr_in_range(s_axi_araddr)) begin
        rresp_next = RESP_SLVERR;
      end else if (s_axi_araddr[ADDR_W-1:0] == FIRST_CTRL_OFS) begin
        rdata_next[CTRL_W-1:0] = first_ctrl_reg;
      end else if (s_axi_araddr[ADDR_W-1:0] == SECOND_CTRL_OFS) begin
        rdata_next[CTRL_W-1:0] = second_ctrl_reg;
      end else if (s_axi_araddr[ADDR_W-1:0] == STATUS_OFS) begin
        rdata_next[ST_T2_POS]   = flags_reg.t2_flag;
        rdata_next[ST_T3_POS]   = flags_reg.t3_flag;
        rdata_next[ST_VDET_POS] = flags_reg.vdet_armed;
        rdata_next[ST_SKIP_POS] = flags_reg.skip;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    // answer taken, reopen the address channel
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  // read channel flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= DATA_ZERO;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a flop
  assign skip_next           = flags_reg.skip;
  assign sys_reset_req       = sysrst_reg;
  assign vdet_armed          = flags_reg.vdet_armed;
  assign timer2_request_flag = flags_reg.t2_flag;
  assign timer3_request_flag = flags_reg.t3_flag;
  assign s_axi_awready       = awready_reg;
  assign s_axi_wready        = wready_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = arready_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;

endmodule : flag_skip_unit

// ---- hdl/flag_skip_pkg.sv ----
// constants, codes and carrier types for the timer flag skip unit
package flag_skip_pkg;

  // ----------------------------------------------------------------
  // instruction word
  // ----------------------------------------------------------------
  localparam int          INSTR_W        = 10;        // word width
  localparam logic [9:0]  OP_SKIP_T3     = 10'h282;   // timer 3 skip
  localparam logic [9:0]  OP_SKIP_T2     = 10'h2A0;   // timer 2 skip
  localparam logic [9:0]  OP_SYS_RESET   = 10'h001;   // system reset
  localparam logic [9:0]  OP_VDET_ARM    = 10'h293;   // detector arm

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 4;         // decoded bits
  localparam logic [3:0]  FIRST_CTRL_OFS = 4'h0;      // first control
  localparam logic [3:0]  SECOND_CTRL_OFS = 4'h4;     // second control
  localparam logic [3:0]  STATUS_OFS     = 4'h8;      // read-only state

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_W         = 4;         // control width
  localparam int          T2_GATE_POS    = 3;         // in first control
  localparam int          T3_GATE_POS    = 0;         // in second control
  localparam logic [3:0]  CTRL_RST       = 4'h0;      // control reset
  localparam int          ST_T2_POS      = 0;         // status bits
  localparam int          ST_T3_POS      = 1;
  localparam int          ST_VDET_POS    = 2;
  localparam int          ST_SKIP_POS    = 3;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;      // accepted
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;      // unmapped
  localparam logic [31:0] DATA_ZERO      = 32'h00000000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // one-hot decode of the supported instructions
  typedef struct packed {
    logic skip_t3;                                    // timer 3 skip
    logic skip_t2;                                    // timer 2 skip
    logic sys_reset;                                  // system reset
    logic vdet_arm;                                   // detector arm
  } decode_t;

  // core-visible flag state
  typedef struct packed {
    logic t2_flag;                                    // timer 2 request
    logic t3_flag;                                    // timer 3 request
    logic vdet_armed;                                 // detector armed
    logic skip;                                       // skip next word
  } flags_t;

  localparam flags_t FLAGS_RST = '{default: 1'b0};    // after reset

endpackage : flag_skip_pkg

// ---- hdl/instr_decode.sv ----
// decodes an instruction word into the unit's one-hot operations
`timescale 1ns/1ps

module instr_decode
  import flag_skip_pkg::*;
(
  input  wire logic [INSTR_W-1:0] code,
  input  wire logic               valid,
  output decode_t                 dec
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // exact compare of the full word, qualified by valid
  always_comb begin
    dec           = '{default: 1'b0};
    dec.skip_t3   = valid && (code == OP_SKIP_T3);
    dec.skip_t2   = valid && (code == OP_SKIP_T2);
    dec.sys_reset = valid && (code == OP_SYS_RESET);
    dec.vdet_arm  = valid && (code == OP_VDET_ARM);
  end

endmodule : instr_decode

// ---- verification/flag_skip_chk.sv ----
// concurrent checks on the core side of the timer flag skip unit
`timescale 1ns/1ps

module flag_skip_chk
  import flag_skip_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               instr_valid,
  input wire logic [INSTR_W-1:0] instr_code,
  input wire logic               timer2_event,
  input wire logic               timer3_event,
  input wire logic               skip_next,
  input wire logic               sys_reset_req,
  input wire logic               vdet_armed,
  input wire logic               timer2_request_flag,
  input wire logic               timer3_request_flag
);
  // ----------------------------------------------------------------
  // clocking and shared sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // timer 3 skip meets a set flag with no new event
  sequence t3_set;
    instr_valid && instr_code == OP_SKIP_T3 && timer3_request_flag
      && !timer3_event;
  endsequence

  // timer 2 skip meets a set flag with no new event
  sequence t2_set;
    instr_valid && instr_code == OP_SKIP_T2 && timer2_request_flag
      && !timer2_event;
  endsequence

  // reset instruction taken
  sequence rst_cmd;
    instr_valid && instr_code == OP_SYS_RESET;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  t3_clear_a: assert property (
    t3_set ##1 skip_next |-> !timer3_request_flag)
    else $error("timer 3 flag kept after skip");
  t3_nop_a: assert property (
    t3_set ##1 !skip_next |-> timer3_request_flag)
    else $error("gated timer 3 skip changed flag");
  t3_no_skip_a: assert property (
    instr_valid && instr_code == OP_SKIP_T3 && !timer3_request_flag
    |=> !skip_next)
    else $error("timer 3 skip with clear flag");
  skip_cause_a: assert property (
    skip_next |-> $past(instr_valid) &&
    ($past(instr_code) == OP_SKIP_T3 && $past(timer3_request_flag) ||
     $past(instr_code) == OP_SKIP_T2 && $past(timer2_request_flag)))
    else $error("skip without a set flag");
  t2_clear_a: assert property (
    t2_set ##1 skip_next |-> !timer2_request_flag)
    else $error("timer 2 flag kept after skip");
  t2_no_skip_a: assert property (
    instr_valid && instr_code == OP_SKIP_T2 && !timer2_request_flag
    |=> !skip_next)
    else $error("timer 2 skip with clear flag");
  // a timer event beats a same-cycle clear, only the reset word wins
  t3_set_wins_a: assert property (
    timer3_event && !(instr_valid && instr_code == OP_SYS_RESET)
    |=> timer3_request_flag)
    else $error("timer 3 event lost");
  t2_set_wins_a: assert property (
    timer2_event && !(instr_valid && instr_code == OP_SYS_RESET)
    |=> timer2_request_flag)
    else $error("timer 2 event lost");
  rst_effect_a: assert property (rst_cmd |=> sys_reset_req
    && !timer2_request_flag && !timer3_request_flag && !vdet_armed)
    else $error("reset instruction without effect");
  rst_cause_a: assert property (sys_reset_req |->
    $past(instr_valid) && $past(instr_code) == OP_SYS_RESET)
    else $error("reset request without instruction");
  vdet_arm_a: assert property (
    instr_valid && instr_code == OP_VDET_ARM |=> vdet_armed)
    else $error("detector not armed");
  vdet_hold_a: assert property (vdet_armed && !(instr_valid &&
    instr_code == OP_SYS_RESET) |=> vdet_armed)
    else $error("detector disarmed");
endmodule : flag_skip_chk

bind flag_skip_unit flag_skip_chk flag_skip_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
  .instr_code(instr_code), .timer2_event(timer2_event),
  .timer3_event(timer3_event), .skip_next(skip_next),
  .sys_reset_req(sys_reset_req), .vdet_armed(vdet_armed),
  .timer2_request_flag(timer2_request_flag),
  .timer3_request_flag(timer3_request_flag));

// ---- verification/testbench.sv ----
// self-checking bench for the timer flag skip unit
`timescale 1ns/1ps

module testbench
  import flag_skip_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               aclk, aresetn, instr_valid, t2_ev, t3_ev;
  logic [INSTR_W-1:0] instr_code;                  // instruction word
  logic               skip_o, rst_o, vdet_o, t2_f, t3_f;
  logic [31:0]        awaddr, wdata, araddr, rdata;
  logic [3:0]         wstrb;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [1:0]         bresp, rresp;
  int                 n_errors, tests_run;         // verdict counters

  flag_skip_unit flag_skip_unit_inst (
    .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
    .instr_code(instr_code), .timer2_event(t2_ev), .timer3_event(t3_ev),
    .skip_next(skip_o), .sys_reset_req(rst_o), .vdet_armed(vdet_o),
    .timer2_request_flag(t2_f), .timer3_request_flag(t3_f),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // a write: both channels offered, each released once taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er,
                    input logic [3:0] s = 4'hF);
    int i;
    @(posedge aclk);
    awaddr  <= a;
    wstrb   <= s;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 40 && !bvalid; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (i == 40) begin
      n_errors++;
      conclude();
    end
    check(bresp, er, "bresp");
    #1;
  endtask : wr

  // a read: answer taken at the edge where rvalid is seen
  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 40 && !rvalid; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (i == 40) begin
      n_errors++;
      conclude();
    end
    check(rdata, ed, "rdata");
    check(rresp, er, "rresp");
    #1;
  endtask : rd

  // offer one word; consecutive calls give back-to-back words
  task automatic send(input logic [INSTR_W-1:0] c);
    @(posedge aclk);
    instr_valid <= 1'b1;
    instr_code  <= c;
  endtask : send

  // end the word stream; outputs settled on return
  task automatic fin;
    @(posedge aclk);
    instr_valid <= 1'b0;
    #1;
  endtask : fin

  // one-cycle timer request pulses
  task automatic raise(input logic e2, e3);
    @(posedge aclk);
    t2_ev <= e2;
    t3_ev <= e3;
    @(posedge aclk);
    t2_ev <= 1'b0;
    t3_ev <= 1'b0;
    #1;
  endtask : raise

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(32'h0, 32'h0, RESP_OKAY);
    rd(32'h4, 32'h0, RESP_OKAY);
    rd(32'h8, 32'h0, RESP_OKAY);
    rd(32'hC, DATA_ZERO, RESP_SLVERR);
    wr(32'hC, 32'hF, RESP_SLVERR);
    wr(32'h8, 32'hF, RESP_OKAY);
    rd(32'h8, 32'h0, RESP_OKAY);
    $display("done: registers");
  endtask : t_regs

  task automatic t_t3;
    raise(1'b0, 1'b1);
    send(OP_SKIP_T3);
    fin();
    check(skip_o, 32'h1, "t3 skip");
    check(t3_f, 32'h0, "t3 clear");
    send(OP_SKIP_T3);
    fin();
    check(skip_o, 32'h0, "t3 no skip");
    // skip and a new timer 3 event in the same cycle
    raise(1'b0, 1'b1);
    @(posedge aclk);
    instr_valid <= 1'b1;
    instr_code  <= OP_SKIP_T3;
    t3_ev       <= 1'b1;
    @(posedge aclk);
    instr_valid <= 1'b0;
    t3_ev       <= 1'b0;
    #1;
    check(skip_o, 32'h1, "skip with event");
    check(t3_f, 32'h1, "event beats clear");
    $display("done: timer 3 skip");
  endtask : t_t3

  task automatic t_gate;
    wr(32'h4, 32'hE, RESP_OKAY);
    rd(32'h4, 32'hE, RESP_OKAY);
    wr(32'h4, 32'h1, RESP_OKAY, 4'hE);
    rd(32'h4, 32'hE, RESP_OKAY);
    raise(1'b0, 1'b1);
    send(OP_SKIP_T3);
    fin();
    check(skip_o, 32'h1, "upper bits gate");
    wr(32'h4, 32'h1, RESP_OKAY);
    raise(1'b0, 1'b1);
    send(OP_SKIP_T3);
    fin();
    check(skip_o, 32'h0, "gated skip");
    check(t3_f, 32'h1, "gated flag");
    rd(32'h8, 32'h2, RESP_OKAY);
    wr(32'h4, 32'h0, RESP_OKAY);
    $display("done: timer 3 gate");
  endtask : t_gate

  task automatic t_t2;
    raise(1'b1, 1'b0);
    send(OP_SKIP_T3);
    send(OP_SKIP_T2);
    fin();
    check(skip_o, 32'h1, "t2 skip");
    check(t2_f, 32'h0, "t2 clear");
    check(t3_f, 32'h0, "t3 clear");
    send(OP_SKIP_T2);
    fin();
    check(skip_o, 32'h0, "t2 no skip");
    wr(32'h0, 32'h8, RESP_OKAY);
    raise(1'b1, 1'b0);
    send(OP_SKIP_T2);
    fin();
    check(skip_o, 32'h0, "t2 gated");
    check(t2_f, 32'h1, "t2 kept");
    $display("done: timer 2 skip");
  endtask : t_t2

  task automatic t_arm_rst;
    send(OP_VDET_ARM);
    send(OP_SKIP_T3);
    fin();
    check(vdet_o, 32'h1, "armed");
    raise(1'b0, 1'b1);
    rd(32'h8, 32'h7, RESP_OKAY);
    send(OP_SYS_RESET);
    fin();
    check(rst_o, 32'h1, "reset pulse");
    check({t2_f, t3_f, vdet_o}, 32'h0, "state cleared");
    @(posedge aclk);
    #1;
    check(rst_o, 32'h0, "pulse ends");
    rd(32'h0, 32'h0, RESP_OKAY);
    $display("done: arm and reset");
  endtask : t_arm_rst

  // ----------------------------------------------------------------
  // clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    {aresetn, instr_valid, t2_ev, t3_ev, instr_code} = '0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready} = '0;
    {arvalid, rready} = '0;
    wstrb     = 4'hF;
    n_errors  = 0;
    tests_run = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_t3();
    t_gate();
    t_t2();
    t_arm_rst();
    conclude();
  end
endmodule : testbench
